// >>> verilog/pattern_regs.svh
`ifndef PATTERN_REGS_SVH
`define PATTERN_REGS_SVH
// Mode register three fields
`define MR3_PAGE_LSB 0
`define MR3_PAGE_MSB 1
`define MR3_ENABLE_BIT 2
`define MR3_FMT_LSB 11
`define MR3_FMT_MSB 12
// Mode register zero burst-length field
`define MR0_BL_LSB 0
`define MR0_BL_MSB 1
`define MR0_BL_OTF 2'h1
// Readout formats
`define FMT_SERIAL 2'h0
`define FMT_PARALLEL 2'h1
`define FMT_STAGGER 2'h2
// Address bits
`define ADDR_CHOP_BIT 12
`define ADDR_A2_BIT 2
`define ADDR_DATA_MSB 7
// Timing in cycles of ref_clk, latency counter width and reset pattern
`define BURST_CYCLES 4'h8
`define LAT_W 6
`define RP_CYCLES 8'h0E
`define MOD_CYCLES 8'h18
`define WR_PAT_CYCLES 8'h12
`define PAT_EXIT_CYCLES 8'h02
`define RESET_PATTERN 8'h55
`endif

// >>> verilog/pattern_pkg.sv
package pattern_pkg;
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_MRS = 3'h1,
    CMD_RD = 3'h2,
    CMD_WR = 3'h3,
    CMD_REF = 3'h4,
    CMD_PREA = 3'h5
  } cmd_e;
  // Device data width: 4, 8 or 16 lanes
  typedef enum logic [1:0] {
    WIDTH_X4 = 2'h0,
    WIDTH_X8 = 2'h1,
    WIDTH_X16 = 2'h2
  } width_e;
  typedef logic [7:0] pattern_t;
endpackage : pattern_pkg

// >>> verilog/pattern_if.sv
`timescale 1ns/1ns
interface pattern_if;
  logic [2:0] cmd;
  logic [1:0] ba;
  logic [17:0] addr;
  logic [15:0] dq;
  logic dq_valid;
  logic dqs;
  logic fgr_refresh;
  modport device (
    input cmd, ba, addr, fgr_refresh,
    output dq, dq_valid, dqs
  );
  modport controller (
    output cmd, ba, addr, fgr_refresh,
    input dq, dq_valid, dqs
  );
endinterface : pattern_if

// >>> verilog/pattern_device.sv
`timescale 1ns/1ns
`include "pattern_regs.svh"
// =====================================================================
// =====================================================================
module pattern_device (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Latency setup; width_sel is not used
  input wire logic [4:0] additive_latency,
  input wire logic [4:0] cas_latency,
  input wire logic [3:0] parity_latency,
  input wire logic parity_enable,
  input wire pattern_pkg::width_e width_sel,
  // Status
  output logic pattern_mode,
  output logic refresh_violation,
  // Link
  pattern_if.device link
);
  // ===================================================================
  // Mode state
  logic [7:0] pattern_reg [0:3];
  logic [1:0] fmt_reg;
  logic chop_reg;
  logic chop_slot_reg;
  logic [`LAT_W-1:0] lat_cnt_reg [0:7];
  logic [1:0] loc_pipe_reg [0:7];
  logic [7:0] pend_reg;
  logic [1:0] cur_loc_reg;
  logic [3:0] beat_reg;
  logic [15:0] dq_reg;
  logic dqv_reg;
  logic dqs_reg;

  wire is_mrs = link.cmd == pattern_pkg::CMD_MRS;
  wire is_rd = link.cmd == pattern_pkg::CMD_RD && pattern_mode;
  wire is_wr = link.cmd == pattern_pkg::CMD_WR && pattern_mode;
  wire [`LAT_W-1:0] read_lat = `LAT_W'(additive_latency) +
    `LAT_W'(cas_latency) +
    (parity_enable ? `LAT_W'(parity_latency) : `LAT_W'(0));
  wire [2:0] free_slot;
  wire burst_end = beat_reg == `BURST_CYCLES - 4'h1;
  wire [3:0] next_beat = beat_reg + 4'h1;

  function automatic logic [1:0] lane_loc(input logic [1:0] k,
                                          input logic [1:0] i);
    lane_loc = k + i;
  endfunction : lane_loc

  function automatic logic [15:0] beat_data(input logic [1:0] k,
                                            input logic [2:0] b,
                                            input logic [1:0] f,
                                            input logic blank);
    logic [3:0] nib;
    nib = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (f == `FMT_STAGGER) begin
        nib[i] = pattern_reg[lane_loc(k, 2'(i))][b];
      end else if (f == `FMT_PARALLEL) begin
        nib[i] = pattern_reg[2'h0][3'(i)];
      end else begin
        nib[i] = pattern_reg[k][b];
      end
    end
    if (f == `FMT_PARALLEL) begin
      beat_data = {2{pattern_reg[2'h0]}};
    end else begin
      beat_data = {4{nib}};
    end
    if (blank) begin
      beat_data = 16'h0000;
    end
  endfunction : beat_data

  // Lowest free slot in the read latency pipeline
  assign free_slot = !pend_reg[0] ? 3'h0 : !pend_reg[1] ? 3'h1 :
    !pend_reg[2] ? 3'h2 : !pend_reg[3] ? 3'h3 : !pend_reg[4] ? 3'h4 :
    !pend_reg[5] ? 3'h5 : !pend_reg[6] ? 3'h6 : 3'h7;

  // ===================================================================
  // Mode register and pattern storage
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pattern_mode <= 1'b0;
      fmt_reg <= `FMT_SERIAL;
      refresh_violation <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        pattern_reg[i] <= `RESET_PATTERN;
      end
    end else begin
      if (is_mrs) begin
        pattern_mode <= link.addr[`MR3_ENABLE_BIT];
        fmt_reg <= link.addr[`MR3_FMT_MSB:`MR3_FMT_LSB];
      end
      if (is_wr) begin
        pattern_reg[link.ba] <= link.addr[`ADDR_DATA_MSB:0];
      end
      if (pattern_mode && link.cmd == pattern_pkg::CMD_REF &&
          link.fgr_refresh) begin
        refresh_violation <= 1'b1;
      end
    end
  end

  // ===================================================================
  // Read latency pipeline: each read waits its latency, then bursts
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pend_reg <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        lat_cnt_reg[i] <= '0;
        loc_pipe_reg[i] <= 2'h0;
      end
      beat_reg <= 4'h0;
      cur_loc_reg <= 2'h0;
      chop_reg <= 1'b0;
      chop_slot_reg <= 1'b0;
      dq_reg <= 16'h0000;
      dqv_reg <= 1'b0;
      dqs_reg <= 1'b0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (pend_reg[i] && lat_cnt_reg[i] != '0) begin
          lat_cnt_reg[i] <= lat_cnt_reg[i] - `LAT_W'(1);
        end
      end
      if (is_rd) begin
        pend_reg[free_slot] <= 1'b1;
        lat_cnt_reg[free_slot] <= read_lat - `LAT_W'(1);
        loc_pipe_reg[free_slot] <= link.ba;
        chop_slot_reg <= !link.addr[`ADDR_CHOP_BIT];
      end
      // Start a burst when a pending read expires; bursts chain
      dqv_reg <= 1'b0;
      dqs_reg <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (pend_reg[i] && lat_cnt_reg[i] == '0 &&
            (!dqv_reg || burst_end)) begin
          pend_reg[i] <= 1'b0;
          cur_loc_reg <= loc_pipe_reg[i];
          chop_reg <= chop_slot_reg;
          beat_reg <= 4'h0;
          dqv_reg <= 1'b1;
          dqs_reg <= ~dqs_reg;
          dq_reg <= beat_data(loc_pipe_reg[i], 3'h0, fmt_reg, 1'b0);
        end
      end
      // Data, valid and strobe move together so beat 0 is never stale
      if (dqv_reg && !burst_end) begin
        beat_reg <= next_beat;
        dqv_reg <= 1'b1;
        dqs_reg <= ~dqs_reg;
        dq_reg <= beat_data(cur_loc_reg, next_beat[2:0], fmt_reg,
          chop_reg && next_beat[2]);
      end
    end
  end

  assign link.dq = dq_reg;
  assign link.dq_valid = dqv_reg;
  assign link.dqs = dqs_reg;
endmodule : pattern_device

// >>> verilog/pattern_controller.sv
`timescale 1ns/1ns
`include "pattern_regs.svh"
module pattern_controller (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Software port
  input wire logic [3:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata,
  // Setup
  input wire logic dll_locked,
  input wire logic [1:0] mr0_burst_len,
  // Link
  pattern_if.controller link
);
  // ===================================================================
  // Software port: 0 enter, 1 write pattern, 2 read, 3 exit, 4 status
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_PRE = 6'h02,
    ST_MODE = 6'h04,
    ST_READY = 6'h08,
    ST_WAIT = 6'h10,
    ST_EXIT = 6'h20
  } state_e;
  state_e state_reg;
  logic [7:0] wait_reg;
  logic [2:0] cmd_reg;
  logic [1:0] ba_reg;
  logic [17:0] addr_reg;
  logic [15:0] last_dq_reg;
  wire go_wr = sw_wr && state_reg == ST_READY;
  wire chop_bit = mr0_burst_len == `MR0_BL_OTF;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      wait_reg <= 8'h00;
      cmd_reg <= pattern_pkg::CMD_NOP;
      ba_reg <= 2'h0;
      addr_reg <= 18'h00000;
      sw_rdata <= 16'h0000;
      last_dq_reg <= 16'h0000;
    end else begin
      cmd_reg <= pattern_pkg::CMD_NOP;
      if (wait_reg != 8'h00) wait_reg <= wait_reg - 8'h01;
      if (link.dq_valid) last_dq_reg <= link.dq;
      if (sw_rd) begin
        sw_rdata <= sw_addr == 4'h4 ? {10'h000, state_reg} : last_dq_reg;
      end
      case (state_reg)
        ST_IDLE: begin
          // Exit mode-set delay must run out before a new entry
          if (sw_wr && sw_addr == 4'h0 && dll_locked &&
              wait_reg == 8'h00) begin
            cmd_reg <= pattern_pkg::CMD_PREA;
            wait_reg <= `RP_CYCLES;
            addr_reg <= {5'h00, sw_wdata[1:0], 11'h000};
            state_reg <= ST_PRE;
          end
        end
        ST_PRE: begin
          if (wait_reg == 8'h00) begin
            cmd_reg <= pattern_pkg::CMD_MRS;
            addr_reg <= 18'h00004 | (addr_reg & 18'h01800);
            wait_reg <= `MOD_CYCLES;
            state_reg <= ST_MODE;
          end
        end
        ST_MODE: begin
          if (wait_reg == 8'h00) state_reg <= ST_READY;
        end
        ST_READY: begin
          if (go_wr && sw_addr == 4'h1) begin
            cmd_reg <= pattern_pkg::CMD_WR;
            ba_reg <= sw_wdata[9:8];
            addr_reg <= {10'h000, sw_wdata[7:0]};
            wait_reg <= `WR_PAT_CYCLES;
            state_reg <= ST_WAIT;
          end else if (go_wr && sw_addr == 4'h2) begin
            cmd_reg <= pattern_pkg::CMD_RD;
            ba_reg <= sw_wdata[1:0];
            addr_reg <= {5'h00, chop_bit, 12'h000};
          end else if (go_wr && sw_addr == 4'h3) begin
            wait_reg <= `PAT_EXIT_CYCLES;
            state_reg <= ST_EXIT;
          end
        end
        ST_WAIT: begin
          if (wait_reg == 8'h00) state_reg <= ST_READY;
        end
        ST_EXIT: begin
          if (wait_reg == 8'h00) begin
            cmd_reg <= pattern_pkg::CMD_MRS;
            addr_reg <= 18'h00000;
            wait_reg <= `MOD_CYCLES;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  assign link.cmd = cmd_reg;
  assign link.ba = ba_reg;
  assign link.addr = addr_reg;
  assign link.fgr_refresh = 1'b0;
endmodule : pattern_controller

// >>> dv/pattern_chk.sv
`timescale 1ns/1ns
`include "pattern_regs.svh"
// ====================
// Link checker
module pattern_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Link
  input wire logic [2:0] cmd,
  input wire logic [1:0] ba,
  input wire logic [17:0] addr,
  input wire logic [15:0] dq,
  input wire logic dq_valid,
  input wire logic dqs,
  input wire logic fgr_refresh
);
  logic mode_reg;
  logic [2:0] last_reg;
  logic [7:0] since_reg;
  wire issue = cmd != pattern_pkg::CMD_NOP;
  wire mrs = cmd == pattern_pkg::CMD_MRS;
  wire rd = cmd == pattern_pkg::CMD_RD;
  wire wr = cmd == pattern_pkg::CMD_WR;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Saturates so a long idle spell never wraps into a false gap
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mode_reg <= 1'b0;
      last_reg <= pattern_pkg::CMD_NOP;
      since_reg <= 8'hFF;
    end else begin
      if (mrs) mode_reg <= addr[`MR3_ENABLE_BIT];
      if (issue) last_reg <= cmd;
      if (issue) since_reg <= 8'h00;
      else if (since_reg != 8'hFF) since_reg <= since_reg + 8'h01;
    end
  end
  sequence eight_beats;
    dq_valid [*8];
  endsequence
  rd_col_a: assert property (rd |-> addr[1:0] == 2'h0)
    else $error("read column low bits not zero");
  rd_order_a: assert property (rd |-> !addr[`ADDR_A2_BIT])
    else $error("read column bit 2 high");
  mrs_page_a: assert property (mrs && addr[2] |-> addr[1:0] == 2'h0)
    else $error("pattern mode entered on a page other than zero");
  acc_mode_a: assert property (rd || wr |-> mode_reg)
    else $error("pattern access outside pattern mode");
  fine_ref_a: assert property (mode_reg |-> !fgr_refresh)
    else $error("fine refresh while pattern mode on");
  wr_gap_a: assert property (issue && last_reg == pattern_pkg::CMD_WR
    |-> since_reg >= `WR_PAT_CYCLES - 8'h01)
    else $error("command inside write recovery time");
  prea_gap_a: assert property (issue && last_reg == pattern_pkg::CMD_PREA
    |-> since_reg >= `RP_CYCLES - 8'h01)
    else $error("command inside precharge time");
  mrs_gap_a: assert property (issue && last_reg == pattern_pkg::CMD_MRS
    |-> since_reg >= `MOD_CYCLES - 8'h01)
    else $error("command inside mode set delay");
  burst_run_a: assert property ($rose(dq_valid) |-> eight_beats)
    else $error("read burst shorter than eight beats");
  lanes_rep_a: assert property (dq_valid |-> dq[15:8] == dq[7:0]
    && dq[7:4] == dq[3:0])
    else $error("upper lanes differ from lower lanes");
  strobe_tog_a: assert property (dq_valid |-> dqs != $past(dqs))
    else $error("strobe did not toggle on a beat");
endmodule : pattern_chk

// >>> dv/tb_dram_pattern_register_access.sv
`timescale 1ns/1ns
module tb_dram_pattern_register_access;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] sw_addr = 4'h0;
  logic [15:0] sw_wdata = 16'h0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [15:0] sw_rdata;
  logic [15:0] d;
  logic dll_locked = 1'b0;
  logic parity_enable = 1'b0;
  pattern_pkg::width_e width_sel = pattern_pkg::WIDTH_X4;
  logic pattern_mode;
  logic refresh_violation;
  logic prev_valid = 1'b0;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int rd_cyc = 0;
  int lat = 0;
  int runs = 0;
  logic [15:0] beats[$];
  pattern_pkg::pattern_t pat[4] = '{8'h55, 8'h55, 8'h55, 8'h55};
  pattern_if link ();
  pattern_device pattern_device_i (.ref_clk(ref_clk), .srst(srst),
    .additive_latency(5'h02), .cas_latency(5'h05), .parity_latency(4'h3),
    .parity_enable(parity_enable), .width_sel(width_sel),
    .pattern_mode(pattern_mode), .refresh_violation(refresh_violation),
    .link(link));
  pattern_controller pattern_controller_i (.ref_clk(ref_clk), .srst(srst),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .dll_locked(dll_locked), .mr0_burst_len(2'h1),
    .link(link));
  pattern_chk pattern_chk_i (.ref_clk(ref_clk), .srst(srst), .cmd(link.cmd),
    .ba(link.ba), .addr(link.addr), .dq(link.dq), .dq_valid(link.dq_valid),
    .dqs(link.dqs), .fgr_refresh(link.fgr_refresh));
  // ====================
  // Clock and link monitor
  initial forever #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    prev_valid <= link.dq_valid;
    if (link.cmd == pattern_pkg::CMD_RD) rd_cyc <= cyc;
    if (link.dq_valid) beats.push_back(link.dq);
    if (link.dq_valid && !prev_valid) begin
      lat <= cyc - 1 - rd_cyc;
      runs <= runs + 1;
    end
  end
  // ====================
  // Access tasks
  task check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task sw_write(input logic [3:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
  endtask : sw_write
  task sw_read(input logic [3:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    @(negedge ref_clk);
    v = sw_rdata;
  endtask : sw_read
  function logic [15:0] beat(input int k, input int b);
    logic [3:0] n;
    for (int i = 0; i < 4; i++) n[i] = pat[(k + i) % 4][b];
    return {4{n}};
  endfunction : beat
  // Reads go out eight cycles apart so bursts must chain
  task read_all(input int k0, input int n);
    beats.delete();
    runs = 0;
    for (int j = 0; j < n; j++) begin
      sw_write(4'h2, {14'h0000, 2'((k0 + j) % 4)});
      repeat (6) @(posedge ref_clk);
    end
    repeat (40) @(posedge ref_clk);
    check(16'(beats.size()), 16'(n * 8));
    check(16'(runs), 16'h0001);
    for (int j = 0; j < n * 8; j++) begin
      check(beats[j], beat((k0 + j / 8) % 4, j % 8));
    end
  endtask : read_all
  task give_verdict;
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    give_verdict();
  end
  // ====================
  // Test sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    dll_locked <= 1'b1;
    sw_write(4'h0, 16'h0002);
    repeat (50) @(posedge ref_clk);
    check(pattern_mode, 1'b1);
    read_all(0, 1);
    check(16'(lat), 16'h0007);
    for (int k = 0; k < 4; k++) begin
      pat[k] = 8'(8'hA3 + k * 8'h39);
      sw_write(4'h1, {6'h00, 2'(k), pat[k]});
      repeat (24) @(posedge ref_clk);
    end
    width_sel <= pattern_pkg::WIDTH_X16;
    read_all(1, 4);
    sw_read(4'h9, d);
    check(d, beats[$]);
    parity_enable <= 1'b1;
    width_sel <= pattern_pkg::WIDTH_X8;
    read_all(2, 1);
    check(16'(lat), 16'h000A);
    sw_write(4'h3, 16'h0000);
    repeat (50) @(posedge ref_clk);
    check(pattern_mode, 1'b0);
    sw_write(4'h0, 16'h0002);
    repeat (50) @(posedge ref_clk);
    read_all(3, 1);
    check(refresh_violation, 1'b0);
    give_verdict();
  end
endmodule : tb_dram_pattern_register_access
